/* common/ptqel_defs.vh */
/*
  constants for the power timer descriptor and queued error log block:
  register offsets, control bits, log byte positions, counts.
  assumes it is included once per design file by its bare name.
*/
`ifndef PTQEL_DEFS_VH
`define PTQEL_DEFS_VH

// register byte offsets
`define PTQEL_CTRL       8'h00
`define PTQEL_CUR_TIMER  8'h04
`define PTQEL_RECOVERY   8'h08
`define PTQEL_MIN_TIMER  8'h0c
`define PTQEL_MAX_TIMER  8'h10
`define PTQEL_IRQ_STAT   8'h14
`define PTQEL_IRQ_MASK   8'h18
`define PTQEL_LOG_ADDR   8'h1c
`define PTQEL_LOG_DATA   8'h20

// control bits
`define PTQEL_CTRL_EPF   0
`define PTQEL_CTRL_SUP   1
`define PTQEL_CTRL_CTE   2
`define PTQEL_CTRL_RST   3'h0

// interrupt status bits
`define PTQEL_IRQ_ERR    0
`define PTQEL_IRQ_DONE   1
`define PTQEL_IRQ_W      2

// log address register: bit 9 picks the power descriptor page
`define PTQEL_LA_PAGE    9

// descriptor dword positions
`define PTQEL_D_CUR      4'h3
`define PTQEL_D_REC      4'h4
`define PTQEL_D_MIN      4'h5
`define PTQEL_D_MAX      4'h6

// queued error log geometry
`define PTQEL_LOG_LAST   9'h1fe
`define PTQEL_LOG_CSUM   9'h1ff

`endif

/* design/ptqel_pwr_desc.v */
/*
  byte view of the timer part of one 64-byte power condition descriptor.
  assumes the caller holds the timer values; purely combinational.
*/
`timescale 1ns/1ns
`include "ptqel_defs.vh"

module ptqel_pwr_desc #(
  parameter TW = 32
) (
  input  wire [5:0]    idx_i,     // byte index in the descriptor
  input  wire          epf_i,     // extended_power_feature enabled
  input  wire          sup_i,     // condition supported
  input  wire          cte_i,     // current timer enabled request
  input  wire [TW-1:0] cur_i,     // current timer, 100 ms units
  input  wire [TW-1:0] rec_i,     // nominal recovery, 100 ms units
  input  wire [TW-1:0] min_i,     // minimum timer, 100 ms units
  input  wire [TW-1:0] max_i,     // maximum timer, 100 ms units
  output reg  [7:0]    byte_o     // descriptor byte
);

  reg [TW-1:0] word;
  reg [TW-1:0] cur_eff;

  // dword select; values pass unaltered so an all-ones saturated code stays all ones
  always @*
  begin
    cur_eff = (epf_i && sup_i && cte_i) ? cur_i : {TW{1'b0}};
    case (idx_i[5:2])
      `PTQEL_D_CUR: word = cur_eff;
      `PTQEL_D_REC: word = rec_i;
      `PTQEL_D_MIN: word = min_i;
      `PTQEL_D_MAX: word = max_i;
      default:      word = {TW{1'b0}};
    endcase
    byte_o = word[idx_i[1:0]*8 +: 8];  // least significant byte first
  end

endmodule // ptqel_pwr_desc

/* design/ptqel_qel_gen.v */
/*
  queued error log page builder: byte view of the 512-byte page and a
  walker that produces bytes 0..510 once after each capture to form
  the checksum. assumes captured fields stay stable while busy.
*/
`timescale 1ns/1ns
`include "ptqel_defs.vh"

module ptqel_qel_gen (
  input  wire        clk_i,      // clock
  input  wire        rst_i,      // synchronous reset
  input  wire        start_i,    // restart the checksum walk
  input  wire        nq_i,       // nonqueued_flag
  input  wire [4:0]  tag_i,      // queue tag
  input  wire [103:0] regs_i,    // bytes 1..13, byte 1 in low bits
  input  wire [23:0] sense_i,    // key, asc, ascq (key low)
  input  wire [47:0] flba_i,     // final failing address
  input  wire [8:0]  rd_idx_i,   // byte index for reads
  output wire [7:0]  rd_byte_o,  // byte at rd_idx_i
  output reg         busy_o,     // walk in progress
  output reg         done_o      // one-cycle pulse at walk end
);

  reg [8:0] walk;
  reg [7:0] sum;
  reg [7:0] csum;

  function [7:0] log_byte;
    input [8:0] i;
    begin
      if (i == 9'h000)
        log_byte = {nq_i, 2'b00, nq_i ? 5'h00 : tag_i};
      else if (i <= 9'h00d)
        log_byte = regs_i[(i - 9'h001)*8 +: 8];
      else if (i <= 9'h010)
        log_byte = sense_i[(i - 9'h00e)*8 +: 8];
      else if (i <= 9'h016)
        log_byte = flba_i[(i - 9'h011)*8 +: 8];
      else
        log_byte = 8'h00;  // reserved and vendor unique read as zero
    end
  endfunction

  assign rd_byte_o = (rd_idx_i == `PTQEL_LOG_CSUM) ? csum : log_byte(rd_idx_i);

  // one byte per cycle; avoids a second pass or a stored page image
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      walk   <= 9'h000;
      sum    <= 8'h00;
      csum   <= 8'h00;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (start_i)
      begin
        walk   <= 9'h000;
        sum    <= 8'h00;
        busy_o <= 1'b1;
      end
      else if (busy_o)
      begin
        sum  <= sum + log_byte(walk);
        walk <= walk + 9'h001;
        if (walk == `PTQEL_LOG_LAST)
        begin
          csum   <= 8'h00 - (sum + log_byte(walk));
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end

endmodule // ptqel_qel_gen

/* design/ptqel_top.v */
/*
  power condition timer descriptor and queued error log, with a classic
  wishbone slave for software and an error capture port from the
  command engine. assumes one clock; error reports are single pulses.
*/
`timescale 1ns/1ns
`include "ptqel_defs.vh"

module ptqel_top #(
  parameter TW = 32
) (
  input  wire          clk_i,        // 100 MHz clock
  input  wire          rst_i,        // synchronous reset, high
  // wishbone classic slave
  input  wire          cyc_i,        // bus cycle
  input  wire          stb_i,        // strobe
  input  wire          we_i,         // write enable
  input  wire [3:0]    sel_i,        // byte lanes
  input  wire [7:0]    adr_i,        // byte address
  input  wire [31:0]   dat_i,        // write data
  output reg  [31:0]   dat_o,        // read data
  output reg           ack_o,        // acknowledge
  // error report from the command engine
  input  wire          err_valid_i,  // report pulse
  input  wire          err_nq_i,     // nonqueued_flag of the failing command
  input  wire [4:0]    err_tag_i,    // queue tag
  input  wire [7:0]    err_status_i, // status register
  input  wire [7:0]    err_error_i,  // error register
  input  wire [47:0]   err_lba_i,    // block address registers
  input  wire [7:0]    err_device_i, // device register
  input  wire [15:0]   err_count_i,  // count registers
  input  wire [7:0]    err_key_i,    // sense key
  input  wire [7:0]    err_asc_i,    // additional sense code
  input  wire [7:0]    err_ascq_i,   // additional sense code qualifier
  input  wire [47:0]   err_flba_i,   // final failing block address
  // interrupt and status
  output reg           irq_o,        // level interrupt
  output reg           log_valid_o,  // log page checksum ready
  output reg           timer_en_o    // power condition timer armed
);

  // control and timer registers
  reg            epf;
  reg            sup;
  reg            cte;
  reg  [TW-1:0]  cur_timer;
  reg  [TW-1:0]  rec_timer;
  reg  [TW-1:0]  min_timer;
  reg  [TW-1:0]  max_timer;
  reg  [`PTQEL_IRQ_W-1:0] irq_stat;
  reg  [`PTQEL_IRQ_W-1:0] irq_mask;
  reg  [9:0]     log_addr;

  // captured error fields
  reg            cap_nq;
  reg  [4:0]     cap_tag;
  reg  [103:0]   cap_regs;
  reg  [23:0]    cap_sense;
  reg  [47:0]    cap_flba;
  reg            walk_start;

  wire           bus_req;
  wire           wr_en;
  wire           rd_en;
  wire           cte_eff;
  wire [7:0]     desc_byte;
  wire [7:0]     qel_byte;
  wire           walk_busy;
  wire           walk_done;
  reg  [31:0]    rd_mux;
  reg  [TW-1:0]  next_cur;
  reg  [TW-1:0]  next_rec;
  reg  [TW-1:0]  next_min;
  reg  [TW-1:0]  next_max;
  reg  [`PTQEL_IRQ_W-1:0] irq_set;
  reg  [`PTQEL_IRQ_W-1:0] next_stat;
  wire [31:0]    mrg_cur;
  wire [31:0]    mrg_rec;
  wire [31:0]    mrg_min;
  wire [31:0]    mrg_max;

  // one request per ack; the gap after ack keeps a held strobe from double firing
  assign bus_req = cyc_i && stb_i && !ack_o;
  assign wr_en   = bus_req && we_i;
  assign rd_en   = bus_req && !we_i;

  // the enabled flag cannot read set while the feature is off
  assign cte_eff = cte && epf;

  ptqel_pwr_desc #(
    .TW      (TW)
  ) u_desc (
    .idx_i   (log_addr[5:0]),
    .epf_i   (epf),
    .sup_i   (sup),
    .cte_i   (cte_eff),
    .cur_i   (cur_timer),
    .rec_i   (rec_timer),
    .min_i   (min_timer),
    .max_i   (max_timer),
    .byte_o  (desc_byte)
  );

  ptqel_qel_gen u_qel (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .start_i   (walk_start),
    .nq_i      (cap_nq),
    .tag_i     (cap_tag),
    .regs_i    (cap_regs),
    .sense_i   (cap_sense),
    .flba_i    (cap_flba),
    .rd_idx_i  (log_addr[8:0]),
    .rd_byte_o (qel_byte),
    .busy_o    (walk_busy),
    .done_o    (walk_done)
  );

  // per-lane write merge; a lane without its select keeps the stored byte
  genvar ln;
  generate
    for (ln = 0; ln < 4; ln = ln + 1)
    begin : g_lane
      assign mrg_cur[8*ln +: 8] = sel_i[ln] ? dat_i[8*ln +: 8] : cur_timer[8*ln +: 8];
      assign mrg_rec[8*ln +: 8] = sel_i[ln] ? dat_i[8*ln +: 8] : rec_timer[8*ln +: 8];
      assign mrg_min[8*ln +: 8] = sel_i[ln] ? dat_i[8*ln +: 8] : min_timer[8*ln +: 8];
      assign mrg_max[8*ln +: 8] = sel_i[ln] ? dat_i[8*ln +: 8] : max_timer[8*ln +: 8];
    end
  endgenerate

  // write decode; only the addressed timer takes the merged word
  always @*
  begin
    next_cur = cur_timer;
    next_rec = rec_timer;
    next_min = min_timer;
    next_max = max_timer;
    if (wr_en)
    begin
      case (adr_i)
        `PTQEL_CUR_TIMER: next_cur = mrg_cur;
        `PTQEL_RECOVERY:  next_rec = mrg_rec;
        `PTQEL_MIN_TIMER: next_min = mrg_min;
        `PTQEL_MAX_TIMER: next_max = mrg_max;
        default: ;
      endcase
    end
  end

  // these hold across every reset, so they sit outside the reset branch
  always @(posedge clk_i)
  begin
    rec_timer <= next_rec;
    min_timer <= next_min;
    max_timer <= next_max;
  end

  // control bits and current timer; current timer falls back to zero on reset
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      {cte, sup, epf} <= `PTQEL_CTRL_RST;
      cur_timer       <= {TW{1'b0}};
    end
    else
    begin
      cur_timer <= next_cur;
      if (wr_en && adr_i == `PTQEL_CTRL && sel_i[0])
      begin
        epf <= dat_i[`PTQEL_CTRL_EPF];
        sup <= dat_i[`PTQEL_CTRL_SUP];
        cte <= dat_i[`PTQEL_CTRL_CTE];
      end
    end
  end

  // interrupt mask; only lane 0 carries the two event bits
  always @(posedge clk_i)
  begin
    if (rst_i)
      irq_mask <= {`PTQEL_IRQ_W{1'b0}};
    else if (wr_en && adr_i == `PTQEL_IRQ_MASK && sel_i[0])
      irq_mask <= dat_i[`PTQEL_IRQ_W-1:0];
  end

  // log pointer; the page bit stays put so a long read never strays onto the other page
  always @(posedge clk_i)
  begin
    if (rst_i)
      log_addr <= 10'h000;
    else if (wr_en && adr_i == `PTQEL_LOG_ADDR)
      log_addr <= dat_i[9:0];
    else if (rd_en && adr_i == `PTQEL_LOG_DATA)
      log_addr <= {log_addr[9], log_addr[8:0] + 9'h001};  // auto-increment
  end

  // walk restart one cycle after a report, once the new fields are in place
  always @(posedge clk_i)
  begin
    if (rst_i)
      walk_start <= 1'b1;  // an empty log after reset still needs its checksum
    else
      walk_start <= err_valid_i;
  end

  // error capture; a report during a walk restarts it on the new content
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cap_nq     <= 1'b1;
      cap_tag    <= 5'h00;
      cap_regs   <= 104'h0;
      cap_sense  <= 24'h000000;
      cap_flba   <= 48'h000000000000;
    end
    else
    begin
      if (err_valid_i)
      begin
        cap_nq   <= err_nq_i;
        cap_tag  <= err_tag_i;
        cap_regs <= {err_count_i, 8'h00, err_lba_i[47:24], err_device_i,
                     err_lba_i[23:0], err_error_i, err_status_i, 8'h00};
        cap_sense <= {err_ascq_i, err_asc_i, err_key_i};
        cap_flba  <= err_flba_i;
      end
    end
  end

  // sticky events; a new event in the clearing read cycle survives
  always @*
  begin
    irq_set = {`PTQEL_IRQ_W{1'b0}};
    irq_set[`PTQEL_IRQ_ERR]  = err_valid_i;
    irq_set[`PTQEL_IRQ_DONE] = walk_done;
    next_stat = irq_stat;
    if (rd_en && adr_i == `PTQEL_IRQ_STAT)
      next_stat = {`PTQEL_IRQ_W{1'b0}};
    next_stat = next_stat | irq_set;
  end

  // read data mux; unmapped offsets read zero and still ack
  always @*
  begin
    rd_mux = 32'h00000000;
    case (adr_i)
      `PTQEL_CTRL:      rd_mux = {29'h0, cte_eff, sup, epf};
      `PTQEL_CUR_TIMER: rd_mux = (epf && sup && cte_eff) ? cur_timer : 32'h0;
      `PTQEL_RECOVERY:  rd_mux = rec_timer;
      `PTQEL_MIN_TIMER: rd_mux = min_timer;
      `PTQEL_MAX_TIMER: rd_mux = max_timer;
      `PTQEL_IRQ_STAT:  rd_mux = {30'h0, irq_stat};
      `PTQEL_IRQ_MASK:  rd_mux = {30'h0, irq_mask};
      `PTQEL_LOG_ADDR:  rd_mux = {22'h0, log_addr};
      `PTQEL_LOG_DATA:  rd_mux = {24'h0, log_addr[`PTQEL_LA_PAGE] ? desc_byte : qel_byte};
      default:          rd_mux = 32'h00000000;
    endcase
  end

  // bus answer; read data only moves on a read so it holds for the master
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end
    else
    begin
      ack_o <= bus_req;
      if (rd_en)
        dat_o <= rd_mux;
    end
  end

  // sticky status and the level interrupt, both from the same next value
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_stat <= {`PTQEL_IRQ_W{1'b0}};
      irq_o    <= 1'b0;
    end
    else
    begin
      irq_stat <= next_stat;
      irq_o    <= |(next_stat & irq_mask);
    end
  end

  // status levels; log valid stays low from the start pulse to the walk's end
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      log_valid_o <= 1'b0;
      timer_en_o  <= 1'b0;
    end
    else
    begin
      log_valid_o <= !walk_busy && !walk_start;
      // armed only with a nonzero setting and the feature on
      timer_en_o  <= epf && sup && cte_eff && (cur_timer != {TW{1'b0}});
    end
  end

endmodule // ptqel_top

/* verif/ptqel_assertions.sv */
/*
  port checker for ptqel_top: bus answer timing, read data hold,
  checksum walk timing and the interrupt level.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ns

module ptqel_chk (
  input wire logic        clk_i,       // clock
  input wire logic        rst_i,       // synchronous reset
  input wire logic        cyc_i,       // bus cycle
  input wire logic        stb_i,       // strobe
  input wire logic        err_valid_i, // error report pulse
  input wire logic        ack_o,       // acknowledge
  input wire logic [31:0] dat_o,       // read data
  input wire logic        irq_o,       // level interrupt
  input wire logic        log_valid_o  // checksum complete
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // cycles since the last error report or reset; saturates so a stuck walk stays visible
  logic [9:0] walk_cnt;
  always @(posedge clk_i)
    if (rst_i || err_valid_i)
      walk_cnt <= 10'h000;
    else if (walk_cnt != 10'h3ff)
      walk_cnt <= walk_cnt + 10'h001;

  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_report;
    err_valid_i ##2 1'b1;
  endsequence

  AST_ACK_ANSWER: assert property (s_req |=> ack_o)
    else $error("request not answered in one cycle");
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("acknowledge longer than one cycle");
  AST_ACK_CAUSE: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("acknowledge without request");
  AST_DAT_HOLD: assert property (!ack_o |-> $stable(dat_o))
    else $error("read data moved without an answer");
  AST_LV_DROP: assert property (s_report |-> !log_valid_o)
    else $error("log still valid after new report");
  AST_LV_HOLD: assert property (log_valid_o && !err_valid_i
    && !$past(err_valid_i) |=> log_valid_o)
    else $error("log valid dropped without report");
  AST_LV_TIME: assert property ($rose(log_valid_o)
    |-> walk_cnt >= 10'd500 && walk_cnt <= 10'd530)
    else $error("checksum walk length wrong");
  AST_LV_BOUND: assert property (walk_cnt == 10'd540 |-> log_valid_o)
    else $error("checksum walk never ended");
  AST_IRQ_RISE: assert property ($rose(irq_o) |-> $past(err_valid_i) ||
    $past(err_valid_i, 2) || log_valid_o || ack_o || $past(ack_o))
    else $error("interrupt rose without cause");
  AST_IRQ_FALL: assert property ($fell(irq_o) |-> ack_o || $past(ack_o))
    else $error("interrupt fell without bus access");
endmodule // ptqel_chk

bind ptqel_top ptqel_chk i_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .err_valid_i,
  .ack_o, .dat_o, .irq_o, .log_valid_o);

/* verif/ptqel_cmd_model.sv */
/*
  command engine model: issues one error report per request, with
  log byte k of the report carrying base plus k.
  assumes go_i is a one-cycle pulse driven after a rising edge.
*/
`timescale 1ns/1ns

module ptqel_cmd_model (
  input  wire logic         clk_i,       // clock
  input  wire logic         go_i,        // request one report
  input  wire logic         nq_i,        // nonqueued_flag
  input  wire logic [4:0]   tag_i,       // queue tag
  input  wire logic [7:0]   base_i,      // field seed
  output logic              err_valid_o, // report pulse
  output logic              err_nq_o,    // nonqueued_flag out
  output logic [4:0]        err_tag_o,   // tag out
  output logic [183:0]      fld_o        // log bytes 0..22
);
  initial err_valid_o = 1'b0;

  // report pulse one cycle after the request
  always @(posedge clk_i)
    err_valid_o <= go_i;

  // fields show inverted data outside the pulse, so a late capture is seen
  always_comb
  begin
    err_nq_o = err_valid_o ? nq_i : ~nq_i;
    err_tag_o = err_valid_o ? tag_i : ~tag_i;
    for (int k = 0; k < 23; k++)
      fld_o[8*k +: 8] = err_valid_o ? base_i + 8'(k) : ~(base_i + 8'(k));
  end
endmodule // ptqel_cmd_model

/* verif/ptqel_tb_top.sv */
/*
  testbench for ptqel_top: timer registers and descriptor page,
  current timer gating, error capture, checksum and interrupt.
  assumes the command engine model and the bound checker.
*/
`timescale 1ns/1ns
`include "ptqel_defs.vh"

module ptqel_tb_top;
  logic         clk_i = 1'b0;
  logic         rst_i = 1'b1;
  logic         cyc_i = 1'b0;
  logic         stb_i = 1'b0;
  logic         we_i  = 1'b0;
  logic [3:0]   sel_i = 4'hf;
  logic [7:0]   adr_i = 8'h00;
  logic [31:0]  dat_i = 32'h0;
  logic         go    = 1'b0;
  logic         nq    = 1'b0;
  logic [4:0]   tag   = 5'h00;
  logic [7:0]   base  = 8'h00;
  wire  [31:0]  dat_o;
  wire          ack_o, irq_o, log_valid_o, timer_en_o, err_valid, err_nq;
  wire  [4:0]   err_tag;
  wire  [183:0] fld;
  int           errors = 0;
  int           n_tests = 0;

  ptqel_cmd_model i_eng (.clk_i(clk_i), .go_i(go), .nq_i(nq), .tag_i(tag), .base_i(base),
    .err_valid_o(err_valid), .err_nq_o(err_nq), .err_tag_o(err_tag), .fld_o(fld));

  ptqel_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .err_valid_i(err_valid), .err_nq_i(err_nq), .err_tag_i(err_tag),
    .err_status_i(fld[23:16]), .err_error_i(fld[31:24]),
    .err_lba_i({fld[87:64], fld[55:32]}), .err_device_i(fld[63:56]),
    .err_count_i(fld[111:96]), .err_key_i(fld[119:112]), .err_asc_i(fld[127:120]),
    .err_ascq_i(fld[135:128]), .err_flba_i(fld[183:136]), .irq_o(irq_o),
    .log_valid_o(log_valid_o), .timer_en_o(timer_en_o));

  // 100 MHz clock
  always #5 clk_i = ~clk_i;

  task automatic results;
    if (errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask

  // one classic cycle, held until ack is sampled high; bounded wait
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack_o !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      errors++;
      results();
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic do_reset;
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  task automatic wait_lv;
    int n;
    n = 0;
    while (log_valid_o !== 1'b1 && n < 700)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 700)
    begin
      errors++;
      results();
    end
  endtask

  // timer values written, device reset, then read back both ways
  task automatic s_timers;
    logic [31:0] v [3];
    logic [31:0] q;
    v = '{32'h1234_5678, 32'h0000_0000, 32'hffff_ffff};
    for (int k = 0; k < 3; k++)
      wb(1'b1, `PTQEL_RECOVERY + 8'(4*k), v[k], q);
    do_reset();
    for (int k = 0; k < 3; k++)
    begin
      wb(1'b0, `PTQEL_RECOVERY + 8'(4*k), 32'h0, q);
      chk("timer reg", q, v[k]);
    end
    wb(1'b1, `PTQEL_LOG_ADDR, 32'h0000_0210, q);
    for (int k = 0; k < 12; k++)
    begin
      wb(1'b0, `PTQEL_LOG_DATA, 32'h0, q);
      chk("desc timer byte", q, {24'h0, v[k/4][8*(k%4) +: 8]});
    end
    // a write with one lane selected changes that byte only
    sel_i <= 4'h2;
    wb(1'b1, `PTQEL_MIN_TIMER, 32'hffff_ffff, q);
    sel_i <= 4'hf;
    wb(1'b0, `PTQEL_MIN_TIMER, 32'h0, q);
    chk("lane merge", q, 32'h0000_ff00);
  endtask

  // every control combination against the current timer view
  task automatic s_cur;
    logic [31:0] q;
    logic [31:0] eff;
    wb(1'b1, `PTQEL_CTRL, 32'h7, q);
    wb(1'b1, `PTQEL_CUR_TIMER, 32'h8421_0c3f, q);
    wb(1'b0, 8'h40, 32'h0, q);
    chk("unmapped", q, 32'h0);
    for (int c = 0; c < 8; c++)
    begin
      eff = (c == 7) ? 32'h8421_0c3f : 32'h0;
      wb(1'b1, `PTQEL_CTRL, 32'(c), q);
      wb(1'b0, `PTQEL_CTRL, 32'h0, q);
      chk("ctrl", q, 32'(c & ((c % 2) ? 7 : 3)));
      wb(1'b0, `PTQEL_CUR_TIMER, 32'h0, q);
      chk("cur timer", q, eff);
      chk("timer armed", {31'h0, timer_en_o}, {31'h0, c == 7});
      wb(1'b1, `PTQEL_LOG_ADDR, 32'h0000_020c, q);
      for (int k = 0; k < 4; k++)
      begin
        wb(1'b0, `PTQEL_LOG_DATA, 32'h0, q);
        chk("desc cur byte", q, {24'h0, eff[8*k +: 8]});
      end
    end
  endtask

  // one report, interrupt, then the whole page and its checksum
  task automatic s_log(input logic n, input logic [4:0] t, input logic [7:0] b,
                       input logic m);
    logic [31:0] q;
    logic [7:0]  e;
    logic [7:0]  es;
    wait_lv();
    wb(1'b1, `PTQEL_IRQ_MASK, {30'h0, m, m}, q);
    wb(1'b0, `PTQEL_IRQ_STAT, 32'h0, q);
    nq <= n;
    tag <= t;
    base <= b;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("irq after report", {31'h0, irq_o}, {31'h0, m});
    chk("log busy", {31'h0, log_valid_o}, 32'h0);
    wait_lv();
    wb(1'b0, `PTQEL_IRQ_STAT, 32'h0, q);
    chk("status", q & 32'h3, 32'h3);
    chk("irq cleared", {31'h0, irq_o}, 32'h0);
    wb(1'b1, `PTQEL_LOG_ADDR, 32'h0, q);
    es = 8'h00;
    for (int k = 0; k < 512; k++)
    begin
      e = (k == 0) ? (n ? 8'h80 : {3'b000, t}) :
          (k == 1 || k == 11 || k > 22) ? 8'h00 : b + 8'(k);
      if (k == 511)
        e = 8'h00 - es;
      es = es + e;
      wb(1'b0, `PTQEL_LOG_DATA, 32'h0, q);
      chk("log byte", q, {24'h0, e});
    end
  endtask

  initial
  begin
    do_reset();
    s_timers();
    s_cur();
    s_log(1'b0, 5'h1f, 8'h31, 1'b1);
    s_log(1'b1, 5'h0a, 8'hc7, 1'b0);
    results();
  end
endmodule // ptqel_tb_top
